// >>> acd_cfg.svh
// Constants for the comparison diagnostic control block.
`ifndef ACD_CFG_SVH
`define ACD_CFG_SVH

// ---------------------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------------------
`define ACD_ADDR_W           12
`define ACD_OFS_COMPARE_CTRL 12'h33C
`define ACD_OFS_FAULT_INJ    12'h33D
`define ACD_OFS_PROT_CTRL    12'h33E
`define ACD_OFS_SWITCH_EN_HI 12'h338
`define ACD_OFS_SWITCH_EN_LO 12'h339
`define ACD_OFS_THR_CELL     12'h33A
`define ACD_OFS_THR_WIRE     12'h33B
`define ACD_OFS_STATUS       12'h340
`define ACD_OFS_FAIL         12'h341

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define ACD_BIT_CMP_GO       0
`define ACD_BIT_SEL_LSB      1
`define ACD_BIT_SINK_LSB     4
`define ACD_BIT_SW_GO        6
`define ACD_BIT_FILT_INJ     0
`define ACD_BIT_CMP_INJ      1
`define ACD_BIT_KEEP         0
`define ACD_BIT_HOLD         7
`define ACD_RESET_BYTE       8'h00

// ---------------------------------------------------------------------------
// Threshold encodings in millivolts
// ---------------------------------------------------------------------------
`define ACD_CELL_THR_BASE_MV 16'd6
`define ACD_CELL_THR_STEP_MV 16'd3
`define ACD_WIRE_THR_BASE_MV 16'd500
`define ACD_WIRE_THR_STEP_MV 16'd300
`define ACD_IN_THR_BASE_MV   16'd4
`define ACD_IN_THR_STEP_MV   16'd4

// Channels walked per check, and inputs the input check can enable.
`define ACD_NUM_CH           16
`define ACD_NUM_IN           8

`endif

// >>> acd_diag_ctrl.sv
// Comparison diagnostic control: registers, override, sinks and check sequencer.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "acd_cfg.svh"
module acd_diag_ctrl (
  // Clock and reset.
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Register port.
  input  wire logic [11:0]            addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  // Balancing state and switch drive.
  input  wire logic                   balancing_run_i,
  input  wire logic [15:0]            balancing_switch_normal_i,
  output logic      [15:0]            balancing_switch_o,
  // Current sinks.
  output acd_pkg::acd_sink_t          wire_sink_select_o,
  // Converter readings and channel maps.
  input  wire logic                   sample_wr_i,
  input  wire logic [3:0]             sample_ch_i,
  input  wire logic [15:0]            main_cell_reading_i,
  input  wire logic [15:0]            aux_cell_reading_i,
  input  wire logic [15:0]            active_map_i,
  input  wire logic [15:0]            aux_select_map_i,
  input  wire logic [7:0]             input_map_i,
  // Filter diagnostic and protector self-test.
  input  wire logic                   filter_diag_fail_i,
  input  wire logic                   prot_test_fault_i,
  input  wire logic                   prot_chan_next_i,
  output logic                        filter_fail_flag_o,
  output logic                        fault_out_n_o
);
  import acd_pkg::*;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] thr_mv(input logic [15:0] base, input logic [15:0] step,
                                         input logic [4:0] code);
    thr_mv = 16'(base + step * {11'h000, code});
  endfunction

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [1:0]  sink_reg, sink_next;
  logic [2:0]  sel_reg, sel_next;
  logic [2:0]  run_sel_reg, run_sel_next;
  logic        cmp_inj_reg, cmp_inj_next;
  logic        filt_inj_reg, filt_inj_next;
  logic        keep_reg, keep_next;
  logic        hold_reg, hold_next;
  logic [15:0] sw_en_reg, sw_en_next;
  logic [4:0]  cell_thr_reg, cell_thr_next;
  logic [3:0]  wire_thr_reg, wire_thr_next;
  logic [2:0]  in_thr_reg, in_thr_next;
  logic [4:0]  done_reg, done_next;
  logic [4:0]  fail_reg, fail_next;
  logic        ovr_reg, ovr_next;
  logic [15:0] ovr_sw_reg, ovr_sw_next;
  logic        bal_q_reg;
  logic        filt_reg, filt_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        go_wr;
  logic        sw_go_wr;
  logic        bal_start;

  assign go_wr    = wr_i && addr_i == `ACD_OFS_COMPARE_CTRL && wdata_i[`ACD_BIT_CMP_GO];
  assign sw_go_wr = wr_i && addr_i == `ACD_OFS_COMPARE_CTRL && wdata_i[`ACD_BIT_SW_GO];
  assign bal_start = balancing_run_i && !bal_q_reg;

  // ---------------------------------------------------------------------------
  // Check sequencer
  // ---------------------------------------------------------------------------
  acd_state_t  st_reg, st_next;
  logic [3:0]  ch_reg, ch_next;
  logic        bad_reg, bad_next;
  logic [15:0] rd_main, rd_aux;
  logic        ch_en;
  logic        ch_bad;
  logic [2:0]  di;

  acd_sample_mem u_mem (
    .clk_i     (clk_i),
    .wr_i      (sample_wr_i),
    .wr_addr_i (sample_ch_i),
    .wr_main_i (main_cell_reading_i),
    .wr_aux_i  (aux_cell_reading_i),
    .rd_addr_i (ch_reg),
    .rd_main_o (rd_main),
    .rd_aux_o  (rd_aux)
  );

  // Per-channel enable and verdict for the running check; the memory read lags one cycle.
  always_comb begin
    ch_en  = 1'b0;
    ch_bad = 1'b0;
    di     = 3'd0;
    case (acd_sel_t'(run_sel_reg))
      ACD_SEL_CELL: begin
        di     = 3'd0;
        ch_en  = aux_select_map_i[ch_reg];
        ch_bad = absdiff(rd_main, rd_aux) >=
                 thr_mv(`ACD_CELL_THR_BASE_MV, `ACD_CELL_THR_STEP_MV, cell_thr_reg);
      end
      ACD_SEL_SENSE: begin
        di     = 3'd1;
        ch_en  = active_map_i[ch_reg];
        ch_bad = rd_main >= thr_mv(`ACD_WIRE_THR_BASE_MV, `ACD_WIRE_THR_STEP_MV, {1'b0, wire_thr_reg});
      end
      ACD_SEL_BAL: begin
        di     = 3'd2;
        ch_en  = aux_select_map_i[ch_reg];
        ch_bad = rd_aux >= thr_mv(`ACD_WIRE_THR_BASE_MV, `ACD_WIRE_THR_STEP_MV, {1'b0, wire_thr_reg});
      end
      ACD_SEL_SWITCH: begin
        di     = 3'd3;
        ch_en  = aux_select_map_i[ch_reg];
        ch_bad = 18'({2'b00, rd_aux} * 3) >= {2'b00, rd_main};
      end
      ACD_SEL_INPUT: begin
        di     = 3'd4;
        ch_en  = ch_reg < 4'(`ACD_NUM_IN) && input_map_i[ch_reg[2:0]];
        ch_bad = absdiff(rd_main, rd_aux) >=
                 thr_mv(`ACD_IN_THR_BASE_MV, `ACD_IN_THR_STEP_MV, {2'b00, in_thr_reg});
      end
      default: begin
        ch_en = 1'b0;
      end
    endcase
  end

  // State walk over all channels: request, then check on the registered read.
  always_comb begin
    st_next   = st_reg;
    ch_next   = ch_reg;
    bad_next  = bad_reg;
    done_next = done_reg;
    fail_next = fail_reg;
    case (st_reg)
      ACD_ST_IDLE: begin
        ch_next  = 4'h0;
        bad_next = 1'b0;
        if (go_wr && wdata_i[3:1] inside {3'b001, 3'b010, 3'b011, 3'b100, 3'b101}) begin
          st_next = ACD_ST_REQ;
        end
      end
      ACD_ST_REQ: begin
        st_next = ACD_ST_CHECK;
      end
      ACD_ST_CHECK: begin
        if (ch_en && ch_bad) begin
          bad_next = 1'b1;
        end
        if (ch_reg == 4'hF) begin
          st_next = ACD_ST_DONE;
        end else begin
          ch_next = 4'(ch_reg + 4'h1);
          st_next = ACD_ST_REQ;
        end
      end
      ACD_ST_DONE: begin
        done_next[di] = 1'b1;
        if (bad_reg || cmp_inj_reg) begin
          fail_next[di] = 1'b1;
        end
        st_next = ACD_ST_IDLE;
      end
      default: begin
        st_next = ACD_ST_IDLE;
      end
    endcase
    // A go that starts a check clears the done and fail flags of all five checks.
    if (st_reg == ACD_ST_IDLE && st_next == ACD_ST_REQ) begin
      done_next = 5'h00;
      fail_next = 5'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes, override and sinks
  // ---------------------------------------------------------------------------
  always_comb begin
    sink_next     = sink_reg;
    sel_next      = sel_reg;
    run_sel_next  = run_sel_reg;
    cmp_inj_next  = cmp_inj_reg;
    filt_inj_next = filt_inj_reg;
    keep_next     = keep_reg;
    hold_next     = hold_reg;
    sw_en_next    = sw_en_reg;
    cell_thr_next = cell_thr_reg;
    wire_thr_next = wire_thr_reg;
    in_thr_next   = in_thr_reg;
    ovr_next      = ovr_reg;
    ovr_sw_next   = ovr_sw_reg;
    if (wr_i) begin
      case (addr_i)
        `ACD_OFS_COMPARE_CTRL: begin
          sink_next = wdata_i[5:4];
          sel_next  = wdata_i[3:1];
          hold_next = wdata_i[`ACD_BIT_HOLD];
        end
        `ACD_OFS_FAULT_INJ: begin
          cmp_inj_next  = wdata_i[`ACD_BIT_CMP_INJ];
          filt_inj_next = wdata_i[`ACD_BIT_FILT_INJ];
        end
        `ACD_OFS_PROT_CTRL:    keep_next = wdata_i[`ACD_BIT_KEEP];
        `ACD_OFS_SWITCH_EN_HI: sw_en_next[15:8] = wdata_i;
        `ACD_OFS_SWITCH_EN_LO: sw_en_next[7:0] = wdata_i;
        `ACD_OFS_THR_CELL:     cell_thr_next = wdata_i[4:0];
        `ACD_OFS_THR_WIRE: begin
          in_thr_next   = wdata_i[6:4];
          wire_thr_next = wdata_i[3:0];
        end
        default: begin
        end
      endcase
    end
    // The running select is latched only by a go write in idle.
    if (go_wr && st_reg == ACD_ST_IDLE) begin
      run_sel_next = wdata_i[3:1];
      if (wdata_i[3:1] == 3'b100) begin
        ovr_next     = !balancing_run_i;
        ovr_sw_next  = sw_en_reg;
      end
    end
    // Switch check end: hold keeps the enabled pattern, else all switches off.
    if (st_reg == ACD_ST_DONE && run_sel_reg == 3'b100 && !hold_reg) begin
      ovr_sw_next = 16'h0000;
    end
    if (sw_go_wr && !balancing_run_i) begin
      ovr_next    = 1'b1;
      ovr_sw_next = sw_en_next;
    end
    if (bal_start) begin
      ovr_next = 1'b0;
    end
  end

  // Filter-fail flag: injection forces it, software clears by writing one to it.
  always_comb begin
    filt_next = filt_reg;
    if (wr_i && addr_i == `ACD_OFS_FAIL && wdata_i[5]) begin
      filt_next = 1'b0;
    end
    if (filter_diag_fail_i || filt_inj_reg) begin
      filt_next = 1'b1;
    end
  end

  // Read mux; the go bits always read zero.
  always_comb begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ACD_OFS_COMPARE_CTRL: rdata_next = {hold_reg, 1'b0, sink_reg, sel_reg, 1'b0};
        `ACD_OFS_FAULT_INJ:    rdata_next = {6'h00, cmp_inj_reg, filt_inj_reg};
        `ACD_OFS_PROT_CTRL:    rdata_next = {7'h00, keep_reg};
        `ACD_OFS_SWITCH_EN_HI: rdata_next = sw_en_reg[15:8];
        `ACD_OFS_SWITCH_EN_LO: rdata_next = sw_en_reg[7:0];
        `ACD_OFS_THR_CELL:     rdata_next = {3'h0, cell_thr_reg};
        `ACD_OFS_THR_WIRE:     rdata_next = {1'b0, in_thr_reg, wire_thr_reg};
        `ACD_OFS_STATUS:       rdata_next = {2'b00, st_reg != ACD_ST_IDLE, done_reg};
        `ACD_OFS_FAIL:         rdata_next = {2'b00, filt_reg, fail_reg};
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // Registers; switch and sink outputs are taken straight from flip-flops.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sink_reg <= 2'b00; sel_reg <= 3'b000; run_sel_reg <= 3'b000;
      cmp_inj_reg <= 1'b0; filt_inj_reg <= 1'b0; keep_reg <= 1'b0; hold_reg <= 1'b0;
      sw_en_reg <= 16'h0000;
      cell_thr_reg <= 5'h00; wire_thr_reg <= 4'h0; in_thr_reg <= 3'h0;
      done_reg <= 5'h00; fail_reg <= 5'h00; ovr_reg <= 1'b0; ovr_sw_reg <= 16'h0000;
      bal_q_reg <= 1'b0; filt_reg <= 1'b0; rdata_reg <= 8'h00;
      st_reg <= ACD_ST_IDLE; ch_reg <= 4'h0; bad_reg <= 1'b0;
      balancing_switch_o <= 16'h0000; wire_sink_select_o <= ACD_SINK_OFF;
    end else begin
      sink_reg <= sink_next; sel_reg <= sel_next; run_sel_reg <= run_sel_next;
      cmp_inj_reg <= cmp_inj_next; filt_inj_reg <= filt_inj_next;
      keep_reg <= keep_next; hold_reg <= hold_next;
      sw_en_reg <= sw_en_next;
      cell_thr_reg <= cell_thr_next; wire_thr_reg <= wire_thr_next; in_thr_reg <= in_thr_next;
      done_reg <= done_next; fail_reg <= fail_next; ovr_reg <= ovr_next; ovr_sw_reg <= ovr_sw_next;
      bal_q_reg <= balancing_run_i; filt_reg <= filt_next; rdata_reg <= rdata_next;
      st_reg <= st_next; ch_reg <= ch_next; bad_reg <= bad_next;
      balancing_switch_o <= (ovr_next && !balancing_run_i) ? ovr_sw_next
                                                           : balancing_switch_normal_i;
      wire_sink_select_o <= acd_sink_t'(sink_next);
    end
  end

  assign rdata_o            = rdata_reg;
  assign filter_fail_flag_o = filt_reg;

  // Protector self-test fault retention.
  acd_prot_seq u_prot (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .keep_i        (keep_reg),
    .test_fault_i  (prot_test_fault_i),
    .chan_next_i   (prot_chan_next_i),
    .fault_held_o  (),
    .fault_out_n_o (fault_out_n_o)
  );

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_go_valid;
    go_wr && st_reg == ACD_ST_IDLE && wdata_i[3:1] inside {3'b001, 3'b010, 3'b011, 3'b100, 3'b101};
  endsequence
  sequence s_done_seen;
    ##[32:34] (done_reg != 5'h00);
  endsequence

  a_sink_immediate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && addr_i == `ACD_OFS_COMPARE_CTRL |=> wire_sink_select_o == acd_sink_t'($past(wdata_i[5:4])))
    else $error("sink select not applied next cycle");
  a_check_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_go_valid |-> s_done_seen)
    else $error("check did not complete in time");
  a_none_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    go_wr && st_reg == ACD_ST_IDLE && wdata_i[3:1] inside {3'b000, 3'b110, 3'b111} |=> st_reg == ACD_ST_IDLE)
    else $error("undefined code started a check");
  a_go_reads_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && addr_i == `ACD_OFS_COMPARE_CTRL |=> !rdata_o[`ACD_BIT_CMP_GO] && !rdata_o[`ACD_BIT_SW_GO])
    else $error("go bit read back as one");
  a_inject_fail: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_reg == ACD_ST_DONE && cmp_inj_reg |=> fail_reg != 5'h00)
    else $error("injected comparison passed");
  a_filter_inj: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    filt_inj_reg |=> filter_fail_flag_o)
    else $error("filter fail not set under injection");
  a_bal_owns: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    balancing_run_i |=> balancing_switch_o == $past(balancing_switch_normal_i))
    else $error("override drove switches while balancing");
  a_override_go: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sw_go_wr && !balancing_run_i |=> balancing_switch_o == $past(sw_en_reg))
    else $error("override pattern not applied");
endmodule // acd_diag_ctrl

// >>> acd_pkg.sv
// Types for the comparison diagnostic control block.
package acd_pkg;
  typedef enum logic [2:0] {
    ACD_SEL_NONE   = 3'b000,
    ACD_SEL_CELL   = 3'b001,
    ACD_SEL_SENSE  = 3'b010,
    ACD_SEL_BAL    = 3'b011,
    ACD_SEL_SWITCH = 3'b100,
    ACD_SEL_INPUT  = 3'b101
  } acd_sel_t;

  typedef enum logic [1:0] {
    ACD_SINK_OFF   = 2'b00,
    ACD_SINK_SENSE = 2'b01,
    ACD_SINK_BAL   = 2'b10,
    ACD_SINK_BUS   = 2'b11
  } acd_sink_t;

  typedef enum logic [1:0] {
    ACD_ST_IDLE  = 2'b00,
    ACD_ST_REQ   = 2'b01,
    ACD_ST_CHECK = 2'b10,
    ACD_ST_DONE  = 2'b11
  } acd_state_t;
endpackage

// >>> acd_prot_seq.sv
// Protector self-test fault handling between channels.
`timescale 1ns/100ps
module acd_prot_seq (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Keep control and self-test events from the protector.
  input  wire logic keep_i,
  input  wire logic test_fault_i,
  input  wire logic chan_next_i,
  // Fault state.
  output logic      fault_held_o,
  output logic      fault_out_n_o
);
  logic held_reg;
  logic held_next;
  logic fo_n_reg;
  logic fo_n_next;

  // A raised fault is kept when asked; otherwise it is dropped on the channel step.
  always_comb begin
    held_next = held_reg;
    if (test_fault_i) begin
      held_next = 1'b1;
    end else if (chan_next_i && !keep_i) begin
      held_next = 1'b0;
    end
    fo_n_next = !held_next;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      held_reg <= 1'b0;
      fo_n_reg <= 1'b1;
    end else begin
      held_reg <= held_next;
      fo_n_reg <= fo_n_next;
    end
  end

  assign fault_held_o  = held_reg;
  assign fault_out_n_o = fo_n_reg;

  a_keep_latched: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    keep_i && held_reg && !test_fault_i |=> held_reg)
    else $error("kept fault dropped");
  a_clear_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    chan_next_i && !keep_i && !test_fault_i |=> !held_reg ##0 fault_out_n_o)
    else $error("fault not cleared on channel step");
endmodule // acd_prot_seq

// >>> acd_sample_mem.sv
// Small memory holding main and auxiliary readings per channel.
`timescale 1ns/100ps
module acd_sample_mem (
  // Clock and write port.
  input  wire logic        clk_i,
  input  wire logic        wr_i,
  input  wire logic [3:0]  wr_addr_i,
  input  wire logic [15:0] wr_main_i,
  input  wire logic [15:0] wr_aux_i,
  // Registered read port.
  input  wire logic [3:0]  rd_addr_i,
  output logic      [15:0] rd_main_o,
  output logic      [15:0] rd_aux_o
);
  logic [15:0] main_mem [0:15];
  logic [15:0] aux_mem  [0:15];

  // Write on strobe; read data come out of a register one cycle later.
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      main_mem[wr_addr_i] <= wr_main_i;
      aux_mem[wr_addr_i]  <= wr_aux_i;
    end
    rd_main_o <= main_mem[rd_addr_i];
    rd_aux_o  <= aux_mem[rd_addr_i];
  end
endmodule // acd_sample_mem

// >>> acd_tb.sv
// Self-checking testbench for the comparison diagnostic control block.
`timescale 1ns/100ps
`include "acd_cfg.svh"
module tb;
  import acd_pkg::*;
  // --------------------------------------------------------------------------
  // Stimulus and observed signals
  // --------------------------------------------------------------------------
  logic        clk_i  = 1'b0;
  logic        rst_n  = 1'b0;
  logic [11:0] addr   = 12'h000;
  logic [7:0]  wdata  = 8'h00;
  logic        wr     = 1'b0;
  logic        rd     = 1'b0;
  logic        run    = 1'b0;
  logic [15:0] nrm    = 16'h0F0F;
  logic        s_wr   = 1'b0;
  logic [3:0]  s_ch   = 4'h0;
  logic        tf     = 1'b0;
  logic        nx     = 1'b0;
  logic        fdf    = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] sw;
  acd_sink_t   sink;
  logic        fault_n;
  logic        ff;
  int          err_total = 0;
  int          cmp_count = 0;

  // Maps are tied fully on so every channel takes part in each check; the input check enables channels 0 to 7 only.
  acd_diag_ctrl acd_diag_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .balancing_run_i(run), .balancing_switch_normal_i(nrm),
    .balancing_switch_o(sw), .wire_sink_select_o(sink), .sample_wr_i(s_wr), .sample_ch_i(s_ch),
    .main_cell_reading_i(16'h0BB8), .aux_cell_reading_i(16'h0BB8), .active_map_i(16'hFFFF),
    .aux_select_map_i(16'hFFFF), .input_map_i(8'hFF), .filter_diag_fail_i(fdf),
    .prot_test_fault_i(tf), .prot_chan_next_i(nx), .filter_fail_flag_o(ff), .fault_out_n_o(fault_n));

  // Free-running bus clock at 40 MHz.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic pulse(input bit next);
    @(posedge clk_i);
    if (next) nx <= 1'b1;
    else tf <= 1'b1;
    @(posedge clk_i);
    nx <= 1'b0;
    tf <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic final_report;
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_sink;
    for (int i = 0; i < 4; i++) begin
      wr_reg(`ACD_OFS_COMPARE_CTRL, 8'(i << 4));
      chk(16'(sink), 16'(i));
    end
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h00);
  endtask

  // Select is parked on the switch-check code; the switch go takes the enables under any select.
  task automatic t_override;
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h08);
    wr_reg(`ACD_OFS_SWITCH_EN_HI, 8'hA5);
    wr_reg(`ACD_OFS_SWITCH_EN_LO, 8'h3C);
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h48);
    chk(sw, 16'hA53C);
    @(posedge clk_i);
    run <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk(sw, 16'h0F0F);
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h48);
    chk(sw, 16'h0F0F);
    // Once balancing stops again the ended override must not come back.
    @(posedge clk_i);
    run <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk(sw, 16'h0F0F);
  endtask

  // Equal readings: delta checks pass, wire checks and the third-of-main check fail.
  task automatic t_checks;
    for (int c = 0; c < 16; c++) begin
      @(posedge clk_i);
      s_wr <= 1'b1;
      s_ch <= 4'(c);
    end
    @(posedge clk_i);
    s_wr <= 1'b0;
    for (int c = 1; c < 6; c++) begin
      wr_reg(`ACD_OFS_COMPARE_CTRL, 8'((c << 1) | 1));
      // A select change without go must not redirect the running check.
      wr_reg(`ACD_OFS_COMPARE_CTRL, 8'((c % 5 + 1) << 1));
      rchk(`ACD_OFS_COMPARE_CTRL, 8'((c % 5 + 1) << 1));
      if (c == 4) chk(sw, 16'hA53C);
      repeat (40) @(posedge clk_i);
      rchk(`ACD_OFS_STATUS, 8'(1 << (c - 1)));
      rchk(`ACD_OFS_FAIL, 8'((5'b01110 >> (c - 1)) & 1) << (c - 1));
      if (c == 4) chk(sw, 16'h0000);
    end
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h01);
    rchk(`ACD_OFS_STATUS, 8'h10);
    wr_reg(`ACD_OFS_FAULT_INJ, 8'h02);
    wr_reg(`ACD_OFS_COMPARE_CTRL, 8'h03);
    repeat (40) @(posedge clk_i);
    rchk(`ACD_OFS_FAIL, 8'h01);
  endtask

  // Filter fail: a diagnostic pulse sets it, and injection holds it against a clear.
  task automatic t_filter;
    chk(ff, 1'b0);
    @(posedge clk_i);
    fdf <= 1'b1;
    @(posedge clk_i);
    fdf <= 1'b0;
    @(posedge clk_i);
    #1 chk(ff, 1'b1);
    wr_reg(`ACD_OFS_FAIL, 8'h20);
    chk(ff, 1'b0);
    wr_reg(`ACD_OFS_FAULT_INJ, 8'h01);
    wr_reg(`ACD_OFS_FAIL, 8'h20);
    rchk(`ACD_OFS_FAIL, 8'h21);
    wr_reg(`ACD_OFS_FAULT_INJ, 8'h00);
    wr_reg(`ACD_OFS_FAIL, 8'h20);
    chk(ff, 1'b0);
  endtask

  task automatic t_prot;
    chk(fault_n, 1'b1);
    pulse(1'b0);
    chk(fault_n, 1'b0);
    pulse(1'b1);
    chk(fault_n, 1'b1);
    wr_reg(`ACD_OFS_PROT_CTRL, 8'h01);
    pulse(1'b0);
    pulse(1'b1);
    chk(fault_n, 1'b0);
  endtask

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n <= 1'b1;
    rchk(`ACD_OFS_COMPARE_CTRL, 8'h00);
    rchk(`ACD_OFS_FAULT_INJ, 8'h00);
    rchk(`ACD_OFS_PROT_CTRL, 8'h00);
    t_sink();
    t_override();
    t_checks();
    t_filter();
    t_prot();
    final_report();
  end

  // Watchdog: the whole run needs well under a thousand cycles.
  initial begin
    #100000;
    err_total++;
    final_report();
  end
endmodule // tb
